// [logic/spo_pkg.sv]
// package for the scaled pulse output block
// shared by the design file and the testbench; no bus, settings arrive as plain inputs
package spo_pkg;
   localparam int unsigned SPO_LEN_W  = 4;
   localparam logic [3:0]  SPO_LEN_MIN = 4'h1;
   localparam logic [3:0]  SPO_LEN_MAX = 4'h9;
   localparam logic [3:0]  SPO_DIGIT_MAX = 4'h9;
   localparam logic [3:0]  SPO_CNT_RST = 4'h0;

   // on-point choice
   typedef enum logic [0:0] {
      SPO_ON_UNITS = 1'b0,
      SPO_ON_TENS  = 1'b1
   } spo_onpt_e;

   typedef enum logic [1:0] {
      SPO_IDLE = 2'b01,
      SPO_HIGH = 2'b10
   } spo_state_e;

   // display update strobe with its two low digits
   typedef struct packed {
      logic       upd;
      logic [3:0] units;
      logic [3:0] tens;
   } spo_disp_s;

   typedef struct packed {
      spo_state_e st;
      logic [3:0] edges;
      logic [3:0] units;
      logic [3:0] tens;
      logic       in_q;
      logic       out;
   } spo_state_s;
endpackage : spo_pkg

// [logic/spo_scaled_pulse.sv]
// scaled pulse output: turns on at display digit change, off after n input edges
// assumes count input and display strobe are synchronous to ref_clk
`timescale 1ns/1ps
// Summary of operation
// - with units on-point the output turns on when an update changes the lowest display digit.
// - with tens on-point the output turns on only when the second digit steps, every ten.
// - once on, the output turns off after the set number (1 to 9) of rising input edges.
// - apart from a manual reset, turn-off is timed only by input rising edges, never by a display change.
// - a manual counter reset turns the output off at once.
module spo_scaled_pulse
   import spo_pkg::*;
(
   // clock and reset
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   // settings
   input  wire logic            pulse_on_point_select,
   input  wire logic [3:0]      pulse_length_edges,
   // counter side
   input  wire logic            count_in,
   input  wire spo_disp_s       disp,
   input  wire logic            manual_reset,
   // output
   output logic                 scaled_out
);
   // refuse settings that the edge counter cannot serve
   if ($bits(pulse_length_edges) != SPO_LEN_W) begin : g_bad_width
      $error("spo: length port width differs from package");
   end
   if (SPO_LEN_MAX > SPO_DIGIT_MAX) begin : g_bad_max
      $error("spo: length limit above one digit");
   end
   if (SPO_LEN_MIN == SPO_CNT_RST) begin : g_bad_min
      $error("spo: length floor must be above zero");
   end

   // whole block state, one register
   spo_state_s s_r;
   spo_state_s s_nxt;
   logic       rise;
   logic       units_step;
   logic       tens_step;
   logic       fire;
   logic [3:0] len_eff;

   always_comb begin
      rise       = count_in & ~s_r.in_q;
      units_step = disp.upd && (disp.units != s_r.units);
      tens_step  = disp.upd && (disp.tens != s_r.tens);
      if (pulse_on_point_select == SPO_ON_TENS) begin
         fire = tens_step;
      end else begin
         fire = units_step;
      end

      // lengths outside 1..9 are clamped
      if (pulse_length_edges < SPO_LEN_MIN) begin
         len_eff = SPO_LEN_MIN;
      end else if (pulse_length_edges > SPO_LEN_MAX) begin
         len_eff = SPO_LEN_MAX;
      end else begin
         len_eff = pulse_length_edges;
      end

      s_nxt      = s_r;
      s_nxt.in_q = count_in;
      // digits follow every update, also while on
      if (disp.upd) begin
         s_nxt.units = disp.units;
         s_nxt.tens  = disp.tens;
      end

      case (s_r.st)
         SPO_IDLE: begin
            if (fire && !manual_reset) begin
               s_nxt.st    = SPO_HIGH;
               s_nxt.out   = 1'b1;
               s_nxt.edges = SPO_CNT_RST;
            end
         end
         SPO_HIGH: begin
            // display changes are ignored here
            if (rise) begin
               if (s_r.edges + 4'h1 >= len_eff) begin
                  s_nxt.st  = SPO_IDLE;
                  s_nxt.out = 1'b0;
               end else begin
                  s_nxt.edges = s_r.edges + 4'h1;
               end
            end
         end
         default: begin
            s_nxt.st  = SPO_IDLE;
            s_nxt.out = 1'b0;
         end
      endcase

      // manual reset wins over a turn-on in the same cycle
      if (manual_reset) begin
         s_nxt.st    = SPO_IDLE;
         s_nxt.out   = 1'b0;
         s_nxt.edges = SPO_CNT_RST;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '{st: SPO_IDLE, edges: SPO_CNT_RST, units: SPO_CNT_RST,
                  tens: SPO_CNT_RST, in_q: 1'b0, out: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // output straight from the state flop
   assign scaled_out = s_r.out;

   // checks, all on the one clock
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // a turn-on that nothing blocks
   sequence s_fire_idle;
      fire && !manual_reset && !scaled_out;
   endsequence

   sequence s_units_mode;
      pulse_on_point_select == SPO_ON_UNITS;
   endsequence

   sequence s_tens_mode;
      pulse_on_point_select == SPO_ON_TENS;
   endsequence

   // a counted input edge while the output is on
   sequence s_live_edge;
      scaled_out && rise && !manual_reset;
   endsequence

   // a counted edge that stays short of the set length
   sequence s_mid_edge;
      s_r.edges + 4'h1 < len_eff;
   endsequence

   // output on with nothing that may end it
   sequence s_quiet_high;
      scaled_out && !rise && !manual_reset;
   endsequence

   a_units_turn_on: assert property (
      (s_units_mode and s_fire_idle) |=> scaled_out)
      else $error("output missed units step");
   a_units_no_step: assert property (
      (s_units_mode and (!units_step && !scaled_out)) |=> !scaled_out)
      else $error("output rose without units step");
   a_on_needs_update: assert property (
      !disp.upd && !scaled_out |=> !scaled_out)
      else $error("output rose without display update");
   a_digits_tracked: assert property (
      disp.upd |=> (s_r.units == $past(disp.units)) && (s_r.tens == $past(disp.tens)))
      else $error("stored digits missed an update");

   a_tens_turn_on: assert property (
      (s_tens_mode and s_fire_idle) |=> scaled_out)
      else $error("output missed tens step");
   a_tens_no_units: assert property (
      (pulse_on_point_select == SPO_ON_TENS) && !tens_step && !scaled_out |=> !scaled_out)
      else $error("output rose without tens step");

   a_len_off_edge: assert property (
      scaled_out && rise && !manual_reset && (s_r.edges + 4'h1 >= len_eff) |=> !scaled_out)
      else $error("output did not end after set edges");
   a_count_step: assert property (
      (s_live_edge and s_mid_edge)
         |=> scaled_out && (s_r.edges == $past(s_r.edges) + 4'h1))
      else $error("edge count did not advance");
   a_len_one_shot: assert property (
      (s_live_edge and (len_eff == SPO_LEN_MIN)) |=> !scaled_out)
      else $error("length one did not end at first edge");
   a_len_full_hold: assert property (
      (s_live_edge and (len_eff == SPO_LEN_MAX) and s_mid_edge) |=> scaled_out)
      else $error("longest length ended early");
   a_edges_below_len: assert property (
      scaled_out |-> s_r.edges < SPO_LEN_MAX)
      else $error("edge count beyond length");
   a_state_matches_out: assert property (
      scaled_out == (s_r.st == SPO_HIGH))
      else $error("output and state disagree");
   a_state_onehot: assert property (
      $onehot(s_r.st))
      else $error("state code not one-hot");

   a_off_only_edge: assert property (
      scaled_out && !rise && !manual_reset |=> scaled_out)
      else $error("output fell without input edge");
   a_count_holds: assert property (
      s_quiet_high |=> $stable(s_r.edges))
      else $error("edge count moved without input edge");
   a_display_ignored: assert property (
      (s_quiet_high and disp.upd) |=> scaled_out)
      else $error("display change ended the output");

   a_manual_off: assert property (
      manual_reset |=> !scaled_out)
      else $error("manual reset left output on");
   a_manual_count: assert property (
      manual_reset |=> s_r.edges == SPO_CNT_RST)
      else $error("manual reset left edge count");

   a_count_cleared: assert property (
      $rose(scaled_out) |-> s_r.edges == SPO_CNT_RST)
      else $error("edge count not cleared at turn on");
   a_on_clears_count: assert property (
      s_fire_idle |=> s_r.edges == SPO_CNT_RST)
      else $error("turn on kept old edge count");
   a_idle_count_hold: assert property (
      !scaled_out && !fire && !manual_reset |=> $stable(s_r.edges))
      else $error("edge count moved while off");
   a_on_from_fire: assert property (
      $rose(scaled_out) |-> $past(fire) && !$past(manual_reset))
      else $error("output rose without a turn-on");
endmodule : spo_scaled_pulse

// [testbench/spo_totalizer.sv]
// partner model: external totalizer counting scaled output pulses
// assumes the pulse is active high and synchronous to ref_clk
`timescale 1ns/1ps
module spo_totalizer (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // pulse from the block
   input  wire logic pulse_in,
   // running total
   output int        total
);
   logic prev_r;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
         total  <= 0;
      end else begin
         prev_r <= pulse_in;
         if (pulse_in && !prev_r)
            total <= total + 1;
      end
   end
endmodule : spo_totalizer

// [testbench/scaled_pulse_output_test.sv]
// testbench: random counter traffic, integer model compared every cycle
// assumes spo_pkg and spo_scaled_pulse are compiled first
`timescale 1ns/1ps
module scaled_pulse_output_test;
   import spo_pkg::*;
   logic       ref_clk, rst_n, sel, cnt, mrst, out;
   logic [3:0] len;
   spo_disp_s  disp;
   int total, miscompares, samples_checked, cyc, n, blk;
   int m_on, m_e, m_u, m_t, m_p, ons;
   spo_scaled_pulse DUT (.ref_clk(ref_clk), .rst_n(rst_n), .pulse_on_point_select(sel),
      .pulse_length_edges(len), .count_in(cnt), .disp(disp), .manual_reset(mrst),
      .scaled_out(out));
   spo_totalizer PLC (.ref_clk(ref_clk), .rst_n(rst_n), .pulse_in(out), .total(total));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task print_verdict;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   // ceiling: 12000 test cycles plus reset and drain, with margin
   always @(posedge ref_clk) begin
      if (cyc > 20000) begin
         miscompares++;
         $display("MISMATCH %0t timeout", $time);
         print_verdict();
      end
   end
   // reference model, settled before the negedge compare
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         m_on = 0; m_e = 0; m_u = 0; m_t = 0; m_p = 0; ons = 0; cyc = 0;
      end else begin
         cyc++;
         n = (len == 4'h0) ? 1 : (len > 4'h9) ? 9 : int'(len);
         if (mrst) m_on = 0;
         else if (m_on != 0 && cnt && m_p == 0) begin
            m_e++;
            if (m_e >= n) m_on = 0;
         end else if (m_on == 0 && disp.upd
                      && (sel ? disp.tens != m_t : disp.units != m_u)) begin
            m_on = 1;
            m_e = 0;
            ons++;
         end
         if (disp.upd) begin
            m_u = disp.units;
            m_t = disp.tens;
         end
         m_p = cnt;
      end
   end
   initial begin
      rst_n = 1'b0; sel = 1'b0; cnt = 1'b0; mrst = 1'b0; len = 4'h1; disp = '0;
      void'($urandom(32'hb17e34db));
      repeat (5) @(posedge ref_clk);
      @(negedge ref_clk) rst_n = 1'b1;
      for (int k = 0; k < 12000; k++) begin
         @(negedge ref_clk);
         samples_checked++;
         if (out !== (m_on != 0)) begin
            miscompares++;
            $display("MISMATCH %0t scaled output differs", $time);
         end
         blk = k / 500;
         len = 4'(blk % 11);
         sel = 1'((blk / 11) % 2);
         cnt = 1'($urandom % 2);
         mrst = ($urandom % 97 == 0);
         disp.upd = ($urandom % 4 == 0);
         disp.units = 4'($urandom % 10);
         disp.tens = 4'($urandom % 3);
      end
      @(negedge ref_clk);
      disp.upd = 1'b0;
      mrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      samples_checked++;
      if (out !== 1'b0) begin
         miscompares++;
         $display("MISMATCH %0t output on after manual reset", $time);
      end
      samples_checked++;
      if (total != ons) begin
         miscompares++;
         $display("MISMATCH %0t totalizer count %0d", $time, total);
      end
      print_verdict();
   end
endmodule : scaled_pulse_output_test
